// ---- src/mts_defines.svh ----
// Purpose: Register map, field positions and timing figures of the
//          motion task sequencer.
// Assumes: Word-addressed Avalon-MM slave, 32-bit data.
// Notes:   Definitions only.
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define REG_STATUS    4'h0
`define REG_START     4'h1
`define REG_SEL       4'h2
`define REG_TPOS      4'h3
`define REG_TVEL      4'h4
`define REG_TACC      4'h5
`define REG_TDEC      4'h6
`define REG_TDWELL    4'h7
`define REG_TCTL      4'h8
`define REG_ACC_LIM   4'h9
`define REG_DEC_LIM   4'ha
`define REG_CMD_POS   4'hb
`define REG_TARGET    4'hc
`define REG_CUSTOM    4'hd

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ST_ACTIVE     0
`define ST_MOVING     1
`define ST_DWELL      2
`define ST_TASK_LSB   8
`define CTL_TYPE      1:0
`define CTL_PROF      3:2
`define CTL_BLEND     5:4
`define CTL_CONSTR    7:6
`define CTL_NEXT_EN   8
`define CTL_NEXT_IDX  23:16

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define LIM_RST       16'hffff
`define CLK_PERIOD_NS 4
`define MS_IN_NS      1000000
`define SCURVE_SHIFT  4

`endif

// ---- src/mts_pkg.sv ----
// Purpose: Types shared by the motion task sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   Task entries are packed so the table is a flop array.
package mts_pkg;

  typedef enum logic [1:0] {ABS, REL_CMD, REL_PREV} motion_type_e;
  typedef enum logic [1:0] {TRAPEZ, SCURVE, CUSTOM} profile_e;
  typedef enum logic [1:0] {BL_NONE, BL_VEL, BL_ACC} blend_e;
  typedef enum logic [1:0] {C_NONE, C_INTR, C_NONINT} constr_e;
  typedef enum logic [1:0] {IDLE, MOVE, DWELL} state_e;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [15:0] vel;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] dwell;
    motion_type_e mtype;
    profile_e prof;
    blend_e blend;
    constr_e constr;
    logic next_en;
    logic [7:0] next_idx;
  } task_s;

  typedef struct packed {
    logic signed [31:0] cmd_pos;
    logic signed [31:0] target;
    logic [15:0] speed;
    logic active;
  } setpoint_s;

endpackage

// ---- src/motion_task_sequencer.sv ----
// Purpose: Stored motion tasks, target computation, ramp profiles and
//          task chaining for a servo drive's position loop.
// Assumes: Start inputs synchronous to i_core_clk; position and speed in
//          counts and counts per clock cycle.
// Notes:   Profile advances every clock cycle.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "mts_defines.svh"

module motion_task_sequencer #(
  parameter int NTASK = 8,
  parameter int TASK_W = 3,
  parameter int CYC_PER_MS = `MS_IN_NS / `CLK_PERIOD_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_start_req,
  input wire logic [TASK_W-1:0] i_start_task,
  output mts_pkg::setpoint_s o_setpoint
);

  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic signed [31:0] calc_target(
      input mts_pkg::task_s t, input logic signed [31:0] cmd,
      input logic signed [31:0] prev);
    unique case (t.mtype)
      mts_pkg::ABS: return t.pos;
      mts_pkg::REL_CMD: return cmd + t.pos;
      default: return prev + t.pos;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  mts_pkg::task_s tbl_r [NTASK];
  mts_pkg::task_s tbl_nxt [NTASK];
  mts_pkg::task_s cur_r, cur_nxt;
  mts_pkg::state_e state_r, state_nxt;
  logic [TASK_W-1:0] sel_r, sel_nxt, cur_idx_r, cur_idx_nxt;
  logic [15:0] acc_lim_r, acc_lim_nxt, dec_lim_r, dec_lim_nxt;
  logic [31:0] cust_r, cust_nxt;
  logic signed [31:0] cmd_pos_r, cmd_pos_nxt, target_r, target_nxt;
  logic signed [31:0] prev_target_r, prev_target_nxt;
  logic [15:0] spd_r, spd_nxt, acc_cur_r, acc_cur_nxt;
  logic [15:0] dwell_ms_r, dwell_ms_nxt;
  logic [31:0] dwell_cyc_r, dwell_cyc_nxt;
  logic rd_ack_r, rd_ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------
  logic sw_start;
  logic [TASK_W-1:0] sw_idx;
  mts_pkg::task_s stask;

  // Reads take one wait cycle so read data always comes from a flop.
  assign o_avs_waitrequest = i_avs_read & ~rd_ack_r;
  assign o_avs_readdata = rdata_r;

  always_comb begin
    tbl_nxt = tbl_r;
    sel_nxt = sel_r;
    acc_lim_nxt = acc_lim_r;
    dec_lim_nxt = dec_lim_r;
    cust_nxt = cust_r;
    sw_start = 1'b0;
    sw_idx = i_avs_writedata[TASK_W-1:0];
    stask = tbl_r[sel_r];
    rd_ack_nxt = i_avs_read & ~rd_ack_r;
    rdata_nxt = rdata_r;
    if (i_avs_write) begin
      unique case (i_avs_address)
        `REG_START: sw_start = 1'b1;
        `REG_SEL: sel_nxt = i_avs_writedata[TASK_W-1:0];
        `REG_TPOS: stask.pos = i_avs_writedata;
        `REG_TVEL: stask.vel = i_avs_writedata[15:0];
        `REG_TACC: stask.acc = i_avs_writedata[15:0];
        `REG_TDEC: stask.dec = i_avs_writedata[15:0];
        `REG_TDWELL: stask.dwell = i_avs_writedata[15:0];
        `REG_TCTL: begin
          stask.mtype = mts_pkg::motion_type_e'(i_avs_writedata[`CTL_TYPE]);
          stask.prof = mts_pkg::profile_e'(i_avs_writedata[`CTL_PROF]);
          stask.blend = mts_pkg::blend_e'(i_avs_writedata[`CTL_BLEND]);
          stask.constr = mts_pkg::constr_e'(i_avs_writedata[`CTL_CONSTR]);
          stask.next_en = i_avs_writedata[`CTL_NEXT_EN];
          stask.next_idx = i_avs_writedata[`CTL_NEXT_IDX];
        end
        `REG_ACC_LIM: acc_lim_nxt = i_avs_writedata[15:0];
        `REG_DEC_LIM: dec_lim_nxt = i_avs_writedata[15:0];
        `REG_CUSTOM: cust_nxt = i_avs_writedata;
        default: ;
      endcase
      tbl_nxt[sel_r] = stask;
    end
    if (i_avs_read && !rd_ack_r) begin
      rdata_nxt = 32'h0;
      unique case (i_avs_address)
        `REG_STATUS: begin
          rdata_nxt[`ST_ACTIVE] = o_setpoint.active;
          rdata_nxt[`ST_MOVING] = (state_r == mts_pkg::MOVE);
          rdata_nxt[`ST_DWELL] = (state_r == mts_pkg::DWELL);
          rdata_nxt[`ST_TASK_LSB +: TASK_W] = cur_idx_r;
        end
        `REG_SEL: rdata_nxt[TASK_W-1:0] = sel_r;
        `REG_TPOS: rdata_nxt = stask.pos;
        `REG_TVEL: rdata_nxt[15:0] = stask.vel;
        `REG_TACC: rdata_nxt[15:0] = stask.acc;
        `REG_TDEC: rdata_nxt[15:0] = stask.dec;
        `REG_TDWELL: rdata_nxt[15:0] = stask.dwell;
        `REG_TCTL: begin
          rdata_nxt[`CTL_TYPE] = stask.mtype;
          rdata_nxt[`CTL_PROF] = stask.prof;
          rdata_nxt[`CTL_BLEND] = stask.blend;
          rdata_nxt[`CTL_CONSTR] = stask.constr;
          rdata_nxt[`CTL_NEXT_EN] = stask.next_en;
          rdata_nxt[`CTL_NEXT_IDX] = stask.next_idx;
        end
        `REG_ACC_LIM: rdata_nxt[15:0] = acc_lim_r;
        `REG_DEC_LIM: rdata_nxt[15:0] = dec_lim_r;
        `REG_CMD_POS: rdata_nxt = cmd_pos_r;
        `REG_TARGET: rdata_nxt = target_r;
        `REG_CUSTOM: rdata_nxt = cust_r;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Start arbitration, profile and chaining
  // --------------------------------------------------------------------
  logic req, ext_ok, chain_now, launch, brake, arrive, same_dir, dir_neg;
  logic [TASK_W-1:0] req_idx, nidx, lidx;
  mts_pkg::task_s rtask, ntask, ltask;
  logic signed [31:0] ntgt, ltgt;
  logic signed [32:0] rem;
  logic [32:0] mag;
  logic [15:0] end_spd, acc_eff, dec_eff, acc_use, spd_new, cust_ent;
  logic [63:0] brk_lhs, brk_rhs;

  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    cur_idx_nxt = cur_idx_r;
    cmd_pos_nxt = cmd_pos_r;
    target_nxt = target_r;
    prev_target_nxt = prev_target_r;
    spd_nxt = spd_r;
    dwell_ms_nxt = dwell_ms_r;
    dwell_cyc_nxt = dwell_cyc_r;
    chain_now = 1'b0;
    req = i_start_req | sw_start;
    req_idx = i_start_req ? i_start_task : sw_idx;
    rtask = tbl_r[req_idx];
    ext_ok = req && !(state_r == mts_pkg::MOVE &&
                      cur_r.constr == mts_pkg::C_NONINT) &&
             (rtask.constr != mts_pkg::C_INTR ||
              (state_r == mts_pkg::MOVE &&
               cur_r.constr == mts_pkg::C_NONE));
    nidx = cur_r.next_idx[TASK_W-1:0];
    ntask = tbl_r[nidx];
    ntgt = calc_target(ntask, target_r, target_r);
    rem = {target_r[31], target_r} - {cmd_pos_r[31], cmd_pos_r};
    dir_neg = rem[32];
    mag = dir_neg ? 33'(-rem) : 33'(rem);
    same_dir = (ntgt != target_r) && ((ntgt < target_r) == dir_neg);
    end_spd = 16'h0;
    if (cur_r.next_en && same_dir) begin
      unique case (cur_r.blend)
        mts_pkg::BL_VEL: end_spd = ntask.vel;
        mts_pkg::BL_ACC: end_spd = spd_r;
        default: ;
      endcase
    end
    acc_eff = min16(cur_r.acc, acc_lim_r);
    dec_eff = min16(cur_r.dec, dec_lim_r);
    cust_ent = {8'h0, cust_r[spd_r[15:14]*8 +: 8]};
    // S-curve ramps acceleration up linearly for a smooth start.
    acc_cur_nxt = min16(acc_cur_r + ((acc_eff >> `SCURVE_SHIFT) | 16'h1),
                        acc_eff);
    unique case (cur_r.prof)
      mts_pkg::SCURVE: acc_use = acc_cur_r;
      mts_pkg::CUSTOM: acc_use = (cust_ent == 16'h0) ? acc_eff :
                                 min16(acc_eff, cust_ent);
      default: acc_use = acc_eff;
    endcase
    brk_lhs = {30'h0, mag, 1'b0} * {48'h0, dec_eff};
    brk_rhs = {32'h0, {16'h0, spd_r} * {16'h0, spd_r}} -
              {32'h0, {16'h0, end_spd} * {16'h0, end_spd}};
    brake = (spd_r > end_spd) && (brk_lhs <= brk_rhs);
    if (brake) begin
      spd_new = (spd_r - end_spd > dec_eff) ? spd_r - dec_eff : end_spd;
      // Creep at one count per cycle so a stop short of target ends.
      if (spd_new == 16'h0)
        spd_new = 16'h1;
    end else if (spd_r < cur_r.vel) begin
      spd_new = (cur_r.vel - spd_r > acc_use) ? spd_r + acc_use :
                cur_r.vel;
    end else if (spd_r > cur_r.vel) begin
      spd_new = (spd_r - cur_r.vel > dec_eff) ? spd_r - dec_eff :
                cur_r.vel;
    end else begin
      spd_new = spd_r;
    end
    arrive = (mag <= {17'h0, spd_new});
    unique case (state_r)
      mts_pkg::IDLE: begin
        spd_nxt = 16'h0;
        acc_cur_nxt = 16'h0;
      end
      mts_pkg::MOVE: begin
        if (arrive) begin
          cmd_pos_nxt = target_r;
          if (cur_r.next_en && cur_r.blend != mts_pkg::BL_NONE &&
              same_dir) begin
            chain_now = 1'b1;
            spd_nxt = spd_new;
          end else if (cur_r.next_en) begin
            spd_nxt = 16'h0;
            chain_now = (cur_r.dwell == 16'h0);
            state_nxt = mts_pkg::DWELL;
            dwell_ms_nxt = 16'h0;
            dwell_cyc_nxt = 32'h0;
          end else begin
            spd_nxt = 16'h0;
            state_nxt = mts_pkg::IDLE;
          end
        end else begin
          cmd_pos_nxt = dir_neg ? cmd_pos_r - {16'h0, spd_new} :
                        cmd_pos_r + {16'h0, spd_new};
          spd_nxt = spd_new;
        end
      end
      mts_pkg::DWELL: begin
        acc_cur_nxt = 16'h0;
        if (dwell_ms_r == cur_r.dwell) begin
          chain_now = 1'b1;
        end else if (dwell_cyc_r == 32'(CYC_PER_MS - 1)) begin
          dwell_cyc_nxt = 32'h0;
          dwell_ms_nxt = dwell_ms_r + 16'h1;
        end else begin
          dwell_cyc_nxt = dwell_cyc_r + 32'h1;
        end
      end
      default: ;
    endcase
    launch = ext_ok | chain_now;
    ltask = ext_ok ? rtask : ntask;
    lidx = ext_ok ? req_idx : nidx;
    ltgt = calc_target(ltask, chain_now && !ext_ok ? target_r : cmd_pos_r,
                       target_r);
    if (launch) begin
      state_nxt = mts_pkg::MOVE;
      cur_nxt = ltask;
      cur_idx_nxt = lidx;
      target_nxt = ltgt;
      prev_target_nxt = ltgt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NTASK; i++)
        tbl_r[i] <= '0;
      cur_r <= '0;
      state_r <= mts_pkg::IDLE;
      sel_r <= '0;
      cur_idx_r <= '0;
      acc_lim_r <= `LIM_RST;
      dec_lim_r <= `LIM_RST;
      cust_r <= 32'h0;
      cmd_pos_r <= 32'sh0;
      target_r <= 32'sh0;
      prev_target_r <= 32'sh0;
      spd_r <= 16'h0;
      acc_cur_r <= 16'h0;
      dwell_ms_r <= 16'h0;
      dwell_cyc_r <= 32'h0;
      rd_ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      tbl_r <= tbl_nxt;
      cur_r <= cur_nxt;
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      cur_idx_r <= cur_idx_nxt;
      acc_lim_r <= acc_lim_nxt;
      dec_lim_r <= dec_lim_nxt;
      cust_r <= cust_nxt;
      cmd_pos_r <= cmd_pos_nxt;
      target_r <= target_nxt;
      prev_target_r <= prev_target_nxt;
      spd_r <= spd_nxt;
      acc_cur_r <= acc_cur_nxt;
      dwell_ms_r <= dwell_ms_nxt;
      dwell_cyc_r <= dwell_cyc_nxt;
      rd_ack_r <= rd_ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_setpoint.cmd_pos = cmd_pos_r;
  assign o_setpoint.target = target_r;
  assign o_setpoint.speed = spd_r;
  assign o_setpoint.active = (state_r != mts_pkg::IDLE);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_launch_of(mts_pkg::motion_type_e t);
    launch && ltask.mtype == t;
  endsequence

  property p_abs;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      s_launch_of(mts_pkg::ABS) |=> target_r == $past(ltask.pos);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");

  property p_rel_cmd;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      s_launch_of(mts_pkg::REL_CMD) ##0 ext_ok |=>
        target_r == $past(cmd_pos_r) + $past(ltask.pos);
  endproperty
  a_rel_cmd: assert property (p_rel_cmd) else $error("rel cmd wrong");

  property p_rel_prev;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      s_launch_of(mts_pkg::REL_PREV) |=>
        target_r == $past(prev_target_r) + $past(ltask.pos);
  endproperty
  a_rel_prev: assert property (p_rel_prev) else $error("rel prev");

  property p_acc_lim;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_r == mts_pkg::MOVE && spd_nxt > spd_r && !launch |->
        spd_nxt - spd_r <= acc_lim_r;
  endproperty
  a_acc_lim: assert property (p_acc_lim) else $error("accel limit");

  property p_dec_lim;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_r == mts_pkg::MOVE && !arrive && spd_nxt < spd_r |->
        spd_r - spd_nxt <= dec_lim_r;
  endproperty
  a_dec_lim: assert property (p_dec_lim) else $error("decel limit");

  property p_nonint;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_r == mts_pkg::MOVE && cur_r.constr == mts_pkg::C_NONINT &&
        !arrive |=> cur_idx_r == $past(cur_idx_r) && $stable(target_r);
  endproperty
  a_nonint: assert property (p_nonint) else $error("non-int broken");

  property p_intr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_r == mts_pkg::IDLE && req && rtask.constr == mts_pkg::C_INTR
        |=> state_r == mts_pkg::IDLE;
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt start");

  property p_active;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      launch |=> o_setpoint.active && o_setpoint.target == $past(ltgt);
  endproperty
  a_active: assert property (p_active) else $error("status bit");

  property p_prev;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      launch |=> prev_target_r == target_r;
  endproperty
  a_prev: assert property (p_prev) else $error("previous target");

  property p_arrive;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_r == mts_pkg::MOVE && arrive && !cur_r.next_en && !ext_ok
        |=> cmd_pos_r == $past(target_r) && spd_r == 16'h0 &&
            state_r == mts_pkg::IDLE;
  endproperty
  a_arrive: assert property (p_arrive) else $error("arrival");

endmodule

// ---- test/mts_partner.sv ----
// Purpose: Far side of the sequencer: task-start inputs and position loop.
// Assumes: Start pulses last one clock cycle.
// Notes:   Task lines toggle between requests so stale numbers never match.
`timescale 1ns/100ps

module mts_partner #(
  parameter int TASK_W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input mts_pkg::setpoint_s i_setpoint,
  output logic o_start_req,
  output logic [TASK_W-1:0] o_start_task
);
  logic signed [31:0] pos_fb_r;
  logic [TASK_W-1:0] req_task_r;
  logic [TASK_W-1:0] idle_task_r;

  // ----
  // Start generator
  // ----
  // The idle pattern lives in its own register so a start never races it.
  assign o_start_task = o_start_req ? req_task_r : idle_task_r;

  initial begin
    o_start_req = 1'b0;
    req_task_r = '0;
    idle_task_r = '0;
  end

  task automatic fire(input logic [TASK_W-1:0] n);
    @(posedge i_core_clk);
    o_start_req <= 1'b1;
    req_task_r <= n;
    @(posedge i_core_clk);
    o_start_req <= 1'b0;
  endtask

  always @(posedge i_core_clk) begin
    idle_task_r <= ~idle_task_r;
  end

  // ----
  // Position loop follower
  // ----
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_fb_r <= 32'h0;
    end else begin
      pos_fb_r <= i_setpoint.cmd_pos;
    end
  end
endmodule

// ---- test/test_motion_task_sequencer.sv ----
// Purpose: Self-checking bench for the motion task sequencer.
// Assumes: One wait cycle per register read, none per write.
// Notes:   Dwell shortened to 10 cycles per millisecond.
`timescale 1ns/100ps
`include "mts_defines.svh"

module test_motion_task_sequencer;
  logic clk;
  logic rst_b;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  logic start_req;
  logic [2:0] start_task;
  mts_pkg::setpoint_s sp;
  int err_total = 0;
  int tests_run = 0;
  int stop_cnt = 0;
  logic [31:0] lfsr = 32'h7337;
  logic ramp_on = 1'b0;
  logic [15:0] sp_p = 16'h0;
  logic [15:0] peak = 16'h0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string nm_q[$];

  always #2 clk = ~clk;

  motion_task_sequencer #(.CYC_PER_MS(10)) motion_task_sequencer_i (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_start_req(start_req), .i_start_task(start_task), .o_setpoint(sp));

  mts_partner #(.TASK_W(3)) mts_partner_i (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_setpoint(sp),
    .o_start_req(start_req), .o_start_task(start_task));

  // ----
  // Checking helpers
  // ----
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] mk(input logic [1:0] ty, pr, bl, co,
                                     input logic ne, input logic [7:0] nx);
    return {8'h0, nx, 7'h0, ne, co, bl, pr, ty};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----
  // Register bus master
  // ----
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    wr <= 1'b0;
  endtask

  // Read data are compared by the monitor below, not here.
  task automatic bus_rd(input logic [3:0] a, input string nm,
                        input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    do @(posedge clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
  endtask

  // Read data are taken at the rising edge that sees waitrequest low.
  always @(posedge clk) begin
    if (rd === 1'b1 && waitreq === 1'b0) begin
      chk(nm_q.pop_front(), rdata & msk_q[0], exp_q.pop_front() & msk_q[0]);
      void'(msk_q.pop_front());
    end
  end

  // The snap to zero speed at the target is a stop, not a ramp step.
  always @(negedge clk) begin
    if (sp.active === 1'b1 && sp.speed === 16'h0) stop_cnt++;
    if (ramp_on) begin
      chk("accel step", {31'h0, sp.speed > sp_p + 16'h0001}, 32'h0);
      chk("decel step", {31'h0, sp.speed != 16'h0 &&
          sp_p > sp.speed + 16'h0002}, 32'h0);
      if (sp.speed != 16'h0)
        chk("loop step", mts_partner_i.pos_fb_r - sp.cmd_pos,
            {16'h0, sp.speed});
      if (sp.speed > peak) peak = sp.speed;
    end
    sp_p = sp.speed;
  end

  // ----
  // Task table and motion helpers
  // ----
  task automatic set_task(input logic [2:0] n,
                          input logic [31:0] p, v, a, d, w, c);
    bus_wr(`REG_SEL, {29'h0, n});
    bus_wr(`REG_TPOS, p);
    bus_wr(`REG_TVEL, v);
    bus_wr(`REG_TACC, a);
    bus_wr(`REG_TDEC, d);
    bus_wr(`REG_TDWELL, w);
    bus_wr(`REG_TCTL, c);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (sp.active !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("idle wait", {31'h0, n >= 4000}, 32'h0);
  endtask

  task automatic go_abs(input logic [31:0] p, v);
    set_task(3'h0, p, v, 32'h2, 32'h2, 32'h0, mk(0, 0, 0, 0, 0, 0));
    mts_partner_i.fire(3'h0);
    wait_idle();
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(`REG_ACC_LIM, "acc limit", 32'h0000ffff, 32'hffffffff);
    bus_rd(`REG_DEC_LIM, "dec limit", 32'h0000ffff, 32'hffffffff);
    bus_rd(4'he, "unmapped", 32'h0, 32'hffffffff);
    bus_rd(`REG_STATUS, "status idle", 32'h0, 32'hffffffff);
    bus_wr(`REG_CUSTOM, 32'h04080c10);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      set_task(3'h0, {24'h0, lfsr[7:0]}, {28'h0, lfsr[11:8]} + 32'h1,
               32'h2, 32'h2, 32'h0, mk(0, i[1:0], 0, 0, 0, 0));
      mts_partner_i.fire(3'h0);
      wait_idle();
      chk("abs cmd", sp.cmd_pos, {24'h0, lfsr[7:0]});
      chk("abs target", sp.target, {24'h0, lfsr[7:0]});
    end
    go_abs(32'd100, 32'h4);
    set_task(3'h1, -32'sd30, 32'h4, 32'h2, 32'h2, 32'h0, mk(1, 0, 0, 0, 0, 0));
    bus_wr(`REG_START, 32'h1);
    wait_idle();
    chk("rel cmd", sp.cmd_pos, 32'd70);
    set_task(3'h2, 32'd50, 32'h1, 32'h1, 32'h1, 32'h0, mk(2, 0, 0, 0, 0, 0));
    set_task(3'h3, 32'd10, 32'h4, 32'h2, 32'h2, 32'h0, mk(2, 0, 0, 0, 0, 0));
    mts_partner_i.fire(3'h2);
    repeat (4) @(posedge clk);
    chk("prev target", sp.target, 32'd120);
    mts_partner_i.fire(3'h3);
    wait_idle();
    chk("prev chain", sp.cmd_pos, 32'd130);
    set_task(3'h4, 32'd0, 32'h2, 32'h2, 32'h2, 32'h0, mk(0, 0, 0, 2, 0, 0));
    mts_partner_i.fire(3'h4);
    bus_rd(`REG_STATUS, "status busy", 32'h401, 32'h701);
    mts_partner_i.fire(3'h0);
    wait_idle();
    chk("nonint", sp.cmd_pos, 32'd0);
    set_task(3'h5, 32'd500, 32'h4, 32'h2, 32'h2, 32'h0, mk(0, 0, 0, 1, 0, 0));
    mts_partner_i.fire(3'h5);
    repeat (3) @(posedge clk);
    chk("intr idle", {31'h0, sp.active}, 32'h0);
    set_task(3'h0, 32'd100, 32'h2, 32'h2, 32'h2, 32'h0, mk(0, 0, 0, 0, 0, 0));
    mts_partner_i.fire(3'h0);
    repeat (5) @(posedge clk);
    mts_partner_i.fire(3'h5);
    wait_idle();
    chk("intr take", sp.cmd_pos, 32'd500);
    for (int b = 0; b < 3; b++) begin
      go_abs(32'd500, 32'h10);
      set_task(3'h6, 32'd600, 32'h4, 32'h2, 32'h2, 32'h3,
               mk(0, 0, b[1:0], 0, 1, 8'h7));
      set_task(3'h7, 32'd700, 32'h6, 32'h2, 32'h2, 32'h0, mk(0, 0, 0, 0, 0, 0));
      stop_cnt = 0;
      mts_partner_i.fire(3'h6);
      wait_idle();
      chk("chain end", sp.cmd_pos, 32'd700);
      if (b == 0)
        chk("dwell", {31'h0, stop_cnt >= 30 && stop_cnt <= 35}, 32'h1);
      else
        chk("blend", {31'h0, stop_cnt < 6}, 32'h1);
    end
    bus_wr(`REG_ACC_LIM, 32'h1);
    bus_wr(`REG_DEC_LIM, 32'h2);
    set_task(3'h0, 32'd520, 32'd100, 32'h4, 32'h4, 32'h0, mk(0, 0, 0, 0, 0, 0));
    peak = 16'h0;
    ramp_on = 1'b1;
    mts_partner_i.fire(3'h0);
    wait_idle();
    ramp_on = 1'b0;
    chk("short peak", {31'h0, peak < 16'd100 && peak > 16'd0}, 32'h1);
    chk("short end", sp.cmd_pos, 32'd520);
    give_verdict();
  end

  // The span covers every move above several times over.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
